// ===== mie_pkg.sv
// Purpose: shared constants and types of the instruction execution unit
// Assumes: byte addressed Avalon-MM slave, one 32-bit word per register
// Notes: opcode field encoding follows the order of mie_op_e
`default_nettype none
package mie_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_EXEC = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PC = 8'h0C;
  localparam logic [7:0] REG_TABLE_HIGH = 8'h10;
  localparam logic [7:0] REG_CYCLES = 8'h14;
  localparam logic [7:0] REG_MEM_ADDR = 8'h18;
  localparam logic [7:0] REG_MEM_DATA = 8'h1C;
  localparam logic [7:0] REG_PROG = 8'h20;
  localparam logic [7:0] REG_CTRL = 8'h24;
  // Instruction word fields
  localparam int EXEC_OP_LSB = 0;
  localparam int EXEC_BIT_LSB = 8;
  localparam int EXEC_ADDR_LSB = 16;
  localparam int EXEC_TARGET_LSB = 16;
  localparam int EXEC_IMM_LSB = 24;
  // Status bits
  localparam int ST_WRAP = 0;
  localparam int ST_NULL = 1;
  localparam int ST_NIBBLE = 2;
  localparam int ST_SIGNED = 3;
  localparam int ST_PDOWN = 4;
  localparam int ST_TIMEOUT = 5;
  localparam int ST_BUSY = 6;
  localparam int ST_SKIP = 7;
  localparam int ST_GIE = 8;
  localparam int ST_PEND = 9;
  localparam int ST_HALT = 10;
  // Program load and control fields
  localparam int PROG_WORD_LSB = 0;
  localparam int PROG_ADDR_LSB = 16;
  localparam int CTRL_WAKE = 0;
  // Sizes and fixed addresses
  localparam int PC_W = 12;
  localparam int PWORD_W = 15;
  localparam int STACK_DEPTH = 6;
  localparam logic [7:0] DMEM_LIMIT = 8'hC0;
  localparam logic [7:0] PC_LOW_ADDR = 8'h06;
  localparam logic [11:0] IRQ_VECTOR = 12'h004;
  localparam logic [3:0] LAST_PAGE = 4'hF;
  localparam logic [2:0] SP_LAST = 3'h5;
  // Reset values and timing
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [11:0] PC_RST = 12'h000;
  localparam int WD_LIMIT_DEF = 65536;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD_CARRY, OP_ADD_CARRY_MEM, OP_ADD, OP_ADD_IMM, OP_SUM_MEM,
    OP_AND, OP_AND_IMM, OP_AND_MEM, OP_CALL, OP_BRANCH, OP_RET, OP_RET_VAL,
    OP_IRQ_RET, OP_CLEAR, OP_CLEAR_BIT, OP_SET_ALL, OP_INVERT, OP_INVERT_ACC,
    OP_SWAP, OP_SWAP_ACC, OP_SKIP_NULL, OP_SKIP_NULL_ACC, OP_SKIP_BIT_ZERO,
    OP_SKIP_BIT_ONE, OP_INC_SKIP, OP_DEC_SKIP, OP_INC_SKIP_ACC, OP_DEC_SKIP_ACC,
    OP_TAB_CUR, OP_TAB_LAST, OP_WD_CLEAR, OP_WD_PRE_A, OP_WD_PRE_B, OP_HALT
  } mie_op_e;

  typedef enum logic [1:0] {EX_IDLE, EX_RUN, EX_DUMMY} mie_state_e;
  typedef enum logic [1:0] {PRE_NONE, PRE_A, PRE_B} mie_pre_e;
endpackage : mie_pkg
`default_nettype wire

// ===== mie_core.sv
// Purpose: executes one instruction per EXEC write on internal memories
// Assumes: software fetches and issues instructions, reading PC back
// Notes: all writes are held off by waitrequest while an instruction runs
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`default_nettype none
// Functional notes
// - taken skip costs two cycles, otherwise one
// - writing the low PC byte takes two cycles
// - paired pre-clears, not single ones, clear timeout and powerdown
// - repeated same pre-clear has no effect
// - watchdog clear resets counter and both flags
// - add with carry into working register
// - add with carry into memory byte
// - three plain add forms update arithmetic flags
// - three AND forms touch only null flag
// - call pushes PC plus one, two cycles
// - byte clear writes zero, no flags
// - bit clear forces one bit low
// - invert memory byte, null flag only
// - inverted byte into working register only
// - nibble swap in place or into register
// - set all ones and no-op leave flags
// - skip on zero byte, optional copy
// - skip on selected bit zero or one
// - increment or decrement then skip on zero
// - branch loads target address, no flags
// - return with value loads working register
// - table fetch splits word to latch and memory
// - halt stops, clears watchdog, sets powerdown
// - interrupt return enables, pending serviced first
module mie_core
  import mie_pkg::*;
#(
  parameter int WD_LIMIT = WD_LIMIT_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Power state
  output logic sys_clk_stop
);
  logic [7:0] dmem [0:191];
  logic [PWORD_W-1:0] pmem [0:4095];
  logic [PC_W-1:0] stack_q [0:STACK_DEPTH-1];
  logic [2:0] sp_q;
  logic [2:0] sp_top;
  mie_state_e st_q;
  mie_pre_e pre_q;
  mie_op_e op;
  logic [31:0] instr_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_val;
  logic wait_q;
  logic [7:0] acc_q;
  logic [PC_W-1:0] pc_q;
  logic wrap_q, null_q, nibble_q, signed_q;
  logic pdown_q, timeout_q, halted_q, gie_q, pend_q, skip_q;
  logic [6:0] thigh_q;
  logic [31:0] cycles_q;
  logic [7:0] maddr_q;
  logic [31:0] wd_cnt_q;
  logic wd_over;
  logic eff, bus_wr, exec_take, wd_clr;
  logic [7:0] m_addr, imm, m_val, opnd, res;
  logic [2:0] bsel;
  logic [PC_W-1:0] target, pc_d;
  logic cin, ovf;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [PWORD_W-1:0] pword;
  logic wr_acc, wr_mem, set_arith, set_null, skip_c, two_c, push, pop, tab;

  assign op = mie_op_e'(instr_q[EXEC_OP_LSB +: 6]);
  assign m_addr = instr_q[EXEC_ADDR_LSB +: 8];
  assign imm = instr_q[EXEC_IMM_LSB +: 8];
  assign bsel = instr_q[EXEC_BIT_LSB +: 3];
  assign target = instr_q[EXEC_TARGET_LSB +: PC_W];
  assign sp_top = (sp_q == 3'h0) ? SP_LAST : sp_q - 3'h1;
  assign bus_wr = avs_write && !wait_q && (avs_byteenable == 4'hF);
  // Instructions issued while halted are accepted and dropped
  assign exec_take = bus_wr && (avs_address == REG_EXEC) && !halted_q;
  assign eff = (st_q == EX_RUN) && !skip_q;
  assign wd_over = (wd_cnt_q == 32'(WD_LIMIT - 1));

  always_comb
  begin
    if (m_addr == PC_LOW_ADDR)
      m_val = pc_q[7:0];
    else if (m_addr < DMEM_LIMIT)
      m_val = dmem[m_addr];
    else
      m_val = 8'h00;
  end

  always_comb
  begin
    opnd = (op == OP_ADD_IMM || op == OP_AND_IMM) ? imm : m_val;
    cin = (op == OP_ADD_CARRY || op == OP_ADD_CARRY_MEM) ? wrap_q : 1'b0;
    sum9 = {1'b0, acc_q} + {1'b0, opnd} + {8'h00, cin};
    sum5 = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
    ovf = (acc_q[7] == opnd[7]) && (sum9[7] != acc_q[7]);
    pword = pmem[{((op == OP_TAB_LAST) ? LAST_PAGE : pc_q[11:8]), acc_q}];
  end

  always_comb
  begin
    res = 8'h00;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    set_arith = 1'b0;
    set_null = 1'b0;
    skip_c = 1'b0;
    two_c = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    tab = 1'b0;
    pc_d = pc_q + 12'h001;
    unique case (op)
      OP_ADD_CARRY: begin res = sum9[7:0]; wr_acc = 1'b1; set_arith = 1'b1; end
      OP_ADD_CARRY_MEM: begin res = sum9[7:0]; wr_mem = 1'b1; set_arith = 1'b1; end
      OP_ADD, OP_ADD_IMM: begin res = sum9[7:0]; wr_acc = 1'b1; set_arith = 1'b1; end
      OP_SUM_MEM: begin res = sum9[7:0]; wr_mem = 1'b1; set_arith = 1'b1; end
      OP_AND, OP_AND_IMM: begin res = acc_q & opnd; wr_acc = 1'b1; set_null = 1'b1; end
      OP_AND_MEM: begin res = acc_q & opnd; wr_mem = 1'b1; set_null = 1'b1; end
      OP_CALL: begin push = 1'b1; pc_d = target; two_c = 1'b1; end
      OP_BRANCH: begin pc_d = target; two_c = 1'b1; end
      OP_RET: begin pop = 1'b1; pc_d = stack_q[sp_top]; two_c = 1'b1; end
      OP_RET_VAL:
      begin
        pop = 1'b1;
        pc_d = stack_q[sp_top];
        res = imm;
        wr_acc = 1'b1;
        two_c = 1'b1;
      end
      // pending request keeps return address stacked
      OP_IRQ_RET:
      begin
        pop = !pend_q;
        pc_d = pend_q ? IRQ_VECTOR : stack_q[sp_top];
        two_c = 1'b1;
      end
      OP_CLEAR: begin res = 8'h00; wr_mem = 1'b1; end
      OP_CLEAR_BIT: begin res = m_val & ~(8'h01 << bsel); wr_mem = 1'b1; end
      OP_SET_ALL: begin res = 8'hFF; wr_mem = 1'b1; end
      OP_INVERT: begin res = ~m_val; wr_mem = 1'b1; set_null = 1'b1; end
      OP_INVERT_ACC: begin res = ~m_val; wr_acc = 1'b1; set_null = 1'b1; end
      OP_SWAP: begin res = {m_val[3:0], m_val[7:4]}; wr_mem = 1'b1; end
      OP_SWAP_ACC: begin res = {m_val[3:0], m_val[7:4]}; wr_acc = 1'b1; end
      OP_SKIP_NULL: skip_c = (m_val == 8'h00);
      OP_SKIP_NULL_ACC: begin res = m_val; wr_acc = 1'b1; skip_c = (m_val == 8'h00); end
      OP_SKIP_BIT_ZERO: skip_c = !m_val[bsel];
      OP_SKIP_BIT_ONE: skip_c = m_val[bsel];
      OP_INC_SKIP, OP_INC_SKIP_ACC:
      begin
        res = m_val + 8'h01;
        wr_mem = (op == OP_INC_SKIP);
        wr_acc = (op == OP_INC_SKIP_ACC);
        skip_c = (res == 8'h00);
      end
      OP_DEC_SKIP, OP_DEC_SKIP_ACC:
      begin
        res = m_val - 8'h01;
        wr_mem = (op == OP_DEC_SKIP);
        wr_acc = (op == OP_DEC_SKIP_ACC);
        skip_c = (res == 8'h00);
      end
      OP_TAB_CUR, OP_TAB_LAST:
      begin
        res = pword[7:0];
        wr_mem = 1'b1;
        tab = 1'b1;
        two_c = 1'b1;
      end
      default: res = 8'h00;
    endcase
    if (wr_mem && m_addr == PC_LOW_ADDR)
    begin
      pc_d = {pc_q[11:8], res};
      two_c = 1'b1;
    end
  end

  assign wd_clr = eff && (op == OP_WD_CLEAR || op == OP_HALT ||
                          (op == OP_WD_PRE_B && pre_q == PRE_A) ||
                          (op == OP_WD_PRE_A && pre_q == PRE_B));

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (avs_address)
      REG_EXEC: rd_val = instr_q;
      REG_ACC: rd_val = {24'h000000, acc_q};
      REG_STATUS: rd_val = {21'h000000, halted_q, pend_q, gie_q, skip_q, (st_q != EX_IDLE),
                            timeout_q, pdown_q, signed_q, nibble_q, null_q, wrap_q};
      REG_PC: rd_val = {20'h00000, pc_q};
      REG_TABLE_HIGH: rd_val = {25'h0000000, thigh_q};
      REG_CYCLES: rd_val = cycles_q;
      REG_MEM_ADDR: rd_val = {24'h000000, maddr_q};
      REG_MEM_DATA: rd_val = (maddr_q < DMEM_LIMIT) ? {24'h000000, dmem[maddr_q]} : 32'h0;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Bus answer one cycle after the request; writes wait for idle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else if (wait_q && (avs_read || (avs_write && st_q == EX_IDLE)))
    begin
      wait_q <= 1'b0;
      rdata_q <= rd_val;
    end
    else
      wait_q <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_q <= EX_IDLE;
      instr_q <= 32'h0000_0000;
      skip_q <= 1'b0;
      cycles_q <= 32'h0000_0000;
    end
    else
    begin
      unique case (st_q)
        EX_IDLE: if (exec_take) st_q <= EX_RUN;
        EX_RUN: st_q <= (eff && two_c) ? EX_DUMMY : EX_IDLE;
        EX_DUMMY: st_q <= EX_IDLE;
      endcase
      if (exec_take)
        instr_q <= avs_writedata;
      if (st_q == EX_RUN)
        skip_q <= eff && skip_c;
      if (st_q != EX_IDLE)
        cycles_q <= cycles_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      acc_q <= ACC_RST;
      pc_q <= PC_RST;
      thigh_q <= 7'h00;
      maddr_q <= 8'h00;
    end
    else
    begin
      if (bus_wr && avs_address == REG_ACC)
        acc_q <= avs_writedata[7:0];
      else if (eff && wr_acc)
        acc_q <= res;
      if (st_q == EX_RUN)
        pc_q <= eff ? pc_d : pc_q + 12'h001;
      if (eff && tab)
        thigh_q <= pword[14:8];
      if (bus_wr && avs_address == REG_MEM_ADDR)
        maddr_q <= avs_writedata[7:0];
    end
  end

  // Memories hold no reset so contents survive halt
  always_ff @(posedge sys_clk)
  begin
    if (bus_wr && avs_address == REG_MEM_DATA && maddr_q < DMEM_LIMIT)
      dmem[maddr_q] <= avs_writedata[7:0];
    else if (eff && wr_mem && m_addr != PC_LOW_ADDR && m_addr < DMEM_LIMIT)
      dmem[m_addr] <= res;
    if (bus_wr && avs_address == REG_PROG)
      pmem[avs_writedata[PROG_ADDR_LSB +: PC_W]] <= avs_writedata[PROG_WORD_LSB +: PWORD_W];
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sp_q <= 3'h0;
      for (int i = 0; i < STACK_DEPTH; i++)
        stack_q[i] <= PC_RST;
    end
    else if (eff && push)
    begin
      stack_q[sp_q] <= pc_q + 12'h001;
      sp_q <= (sp_q == SP_LAST) ? 3'h0 : sp_q + 3'h1;
    end
    else if (eff && pop)
      sp_q <= sp_top;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wrap_q <= 1'b0;
      null_q <= 1'b0;
      nibble_q <= 1'b0;
      signed_q <= 1'b0;
    end
    else if (bus_wr && avs_address == REG_STATUS)
    begin
      wrap_q <= avs_writedata[ST_WRAP];
      null_q <= avs_writedata[ST_NULL];
      nibble_q <= avs_writedata[ST_NIBBLE];
      signed_q <= avs_writedata[ST_SIGNED];
    end
    else if (eff && (set_arith || set_null))
    begin
      null_q <= (res == 8'h00);
      if (set_arith)
      begin
        wrap_q <= sum9[8];
        nibble_q <= sum5[4];
        signed_q <= ovf;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      gie_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else if (bus_wr && avs_address == REG_STATUS)
    begin
      gie_q <= avs_writedata[ST_GIE];
      pend_q <= avs_writedata[ST_PEND];
    end
    else if (eff && op == OP_IRQ_RET)
    begin
      gie_q <= !pend_q;
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      pre_q <= PRE_NONE;
    else if (st_q == EX_RUN)
    begin
      if (eff && op == OP_WD_PRE_A)
        pre_q <= (pre_q == PRE_B) ? PRE_NONE : PRE_A;
      else if (eff && op == OP_WD_PRE_B)
        pre_q <= (pre_q == PRE_A) ? PRE_NONE : PRE_B;
      else
        pre_q <= PRE_NONE;
    end
  end

  // Watchdog overflow beats a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wd_cnt_q <= 32'h0000_0000;
      timeout_q <= 1'b0;
      pdown_q <= 1'b0;
      halted_q <= 1'b0;
      sys_clk_stop <= 1'b0;
    end
    else
    begin
      if (wd_clr || wd_over)
        wd_cnt_q <= 32'h0000_0000;
      else
        wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
      if (wd_over)
        timeout_q <= 1'b1;
      else if (wd_clr)
        timeout_q <= 1'b0;
      if (eff && op == OP_HALT)
      begin
        pdown_q <= 1'b1;
        halted_q <= 1'b1;
        sys_clk_stop <= 1'b1;
      end
      else
      begin
        if (wd_clr)
          pdown_q <= 1'b0;
        if (wd_over || (bus_wr && avs_address == REG_CTRL && avs_writedata[CTRL_WAKE]))
        begin
          halted_q <= 1'b0;
          sys_clk_stop <= 1'b0;
        end
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  AST_SKIP_ONE:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      eff && skip_c |=> st_q == EX_IDLE && skip_q)
    else $error("taken skip did not arm the dummy cycle");
  AST_PC_LOW_TWO:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      eff && wr_mem && m_addr == PC_LOW_ADDR |=> st_q == EX_DUMMY ##1 st_q == EX_IDLE)
    else $error("low PC byte write not two cycles");
  AST_PRE_PAIR:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      eff && op == OP_WD_PRE_B && pre_q == PRE_A |=> !pdown_q && wd_cnt_q == 32'h0)
    else $error("pre-clear pair did not clear");
  AST_PRE_REPEAT:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      eff && op == OP_WD_PRE_A && pre_q == PRE_A |=> $stable(pdown_q) &&
      wd_cnt_q == ($past(wd_over) ? 32'h0 : $past(wd_cnt_q) + 32'h1))
    else $error("repeated pre-clear had an effect");
  AST_CALL_PUSH:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      eff && op == OP_CALL |=> pc_q == $past(target) &&
      stack_q[$past(sp_q)] == $past(pc_q) + 12'h001 ##1 st_q == EX_IDLE)
    else $error("call push or target wrong");
  AST_CLEAR_BYTE:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      eff && op == OP_CLEAR && m_addr < DMEM_LIMIT && m_addr != PC_LOW_ADDR
      |=> dmem[$past(m_addr)] == 8'h00 && $stable(null_q))
    else $error("byte clear failed");
  AST_DUMMY_QUIET:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      st_q == EX_RUN && skip_q |=> $stable(acc_q) && $stable(sp_q) && $stable(thigh_q))
    else $error("skipped instruction had an effect");
  AST_IRQ_RET:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      eff && op == OP_IRQ_RET |=> (gie_q != $past(pend_q)) &&
      (!$past(pend_q) || pc_q == IRQ_VECTOR))
    else $error("interrupt return handling wrong");
  AST_HALT:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      eff && op == OP_HALT |=> pdown_q && sys_clk_stop && wd_cnt_q == 32'h0)
    else $error("halt did not enter power down");
endmodule : mie_core
`default_nettype wire

// ===== mcu_instruction_execution_tb.sv
// Purpose: self-checking bench of the instruction execution unit
// Assumes: registers reached over Avalon-MM, watchdog shortened to 64
// Notes: data ops run three passes, the first with corner values
`default_nettype none
module mcu_instruction_execution_tb import mie_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] acc; logic [7:0] mem; logic [3:0] fl; logic skip;} mie_exp_s;
  logic sys_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sys_clk_stop;
  logic wait_seen;
  logic [31:0] data_seen;
  int err_total = 0;
  int num_checks = 0;
  int seed = 76121;
  mie_op_e ops[19] = '{OP_NOP, OP_ADD_CARRY, OP_ADD_CARRY_MEM, OP_ADD, OP_ADD_IMM, OP_SUM_MEM,
    OP_AND, OP_AND_IMM, OP_AND_MEM, OP_CLEAR, OP_CLEAR_BIT, OP_SET_ALL, OP_INVERT,
    OP_INVERT_ACC, OP_SWAP, OP_SWAP_ACC, OP_SKIP_NULL, OP_SKIP_BIT_ZERO, OP_SKIP_BIT_ONE};
  mie_op_e ops2[5] = '{OP_SKIP_NULL_ACC, OP_INC_SKIP, OP_DEC_SKIP, OP_INC_SKIP_ACC, OP_DEC_SKIP_ACC};

  always #50 sys_clk = ~sys_clk;

  mie_core #(.WD_LIMIT(64)) DUT (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .sys_clk_stop(sys_clk_stop)
  );

  // Registered outputs are steady at the falling edge, so no race at sampling
  always @(negedge sys_clk)
  begin
    wait_seen <= avs_waitrequest;
    data_seen <= avs_readdata;
  end

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic print_verdict();
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic bus_go(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wait_seen !== 1'h0 && n < 40);
    chk_bit("waitrequest", 1'h0, wait_seen);
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask : bus_go

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_go(a, 1'h1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus_go(a, 1'h0, 32'h0);
    d = data_seen;
  endtask : rd

  task automatic run(input logic [31:0] w);
    logic [31:0] st;
    int n;
    n = 0;
    wr(REG_EXEC, w);
    do
    begin
      rd(REG_STATUS, st);
      n++;
    end
    while (st[ST_BUSY] !== 1'h0 && n < 10);
    chk_bit("busy", 1'h0, st[ST_BUSY]);
  endtask : run

  task automatic cyc_run(input logic [31:0] w, input logic [31:0] n);
    logic [31:0] c0;
    logic [31:0] c1;
    rd(REG_CYCLES, c0);
    run(w);
    rd(REG_CYCLES, c1);
    chk_val("cycles", n, c1 - c0);
  endtask : cyc_run

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk_val(what, exp, d);
  endtask : rd_chk

  function automatic logic [31:0] iw(input mie_op_e op, input logic [7:0] ad,
      input logic [7:0] im, input logic [2:0] b);
    return {im, ad, 5'h0, b, 2'h0, op};
  endfunction : iw

  function automatic logic [31:0] tw(input mie_op_e op, input logic [11:0] t);
    return {4'h0, t, 10'h0, op};
  endfunction : tw

  function automatic mie_exp_s model(input mie_op_e op, input logic [7:0] a,
      input logic [7:0] m, input logic [3:0] f, input logic [7:0] im, input logic [2:0] b);
    mie_exp_s e;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] y;
    logic ci;
    e = '{a, m, f, 1'h0};
    ci = (op == OP_ADD_CARRY || op == OP_ADD_CARRY_MEM) ? f[0] : 1'h0;
    y = (op == OP_ADD_IMM || op == OP_AND_IMM) ? im : m;
    s = {1'h0, a} + {1'h0, y} + 9'(ci);
    h = {1'h0, a[3:0]} + {1'h0, y[3:0]} + 5'(ci);
    case (op)
      OP_ADD_CARRY, OP_ADD_CARRY_MEM, OP_ADD, OP_ADD_IMM, OP_SUM_MEM:
      begin
        e.fl = {(a[7] == y[7]) && (s[7] != a[7]), h[4], s[7:0] == 8'h00, s[8]};
        e.mem = (op == OP_ADD_CARRY_MEM || op == OP_SUM_MEM) ? s[7:0] : m;
        e.acc = (e.mem == m && op != OP_ADD_CARRY_MEM && op != OP_SUM_MEM) ? s[7:0] : a;
      end
      OP_AND, OP_AND_IMM, OP_AND_MEM:
      begin
        y = a & y;
        e.fl[1] = y == 8'h00;
        e.mem = (op == OP_AND_MEM) ? y : m;
        e.acc = (op == OP_AND_MEM) ? a : y;
      end
      OP_CLEAR: e.mem = 8'h00;
      OP_CLEAR_BIT: e.mem[b] = 1'h0;
      OP_SET_ALL: e.mem = 8'hFF;
      OP_INVERT, OP_INVERT_ACC:
      begin
        e.fl[1] = m == 8'hFF;
        e.mem = (op == OP_INVERT) ? ~m : m;
        e.acc = (op == OP_INVERT) ? a : ~m;
      end
      OP_SWAP: e.mem = {m[3:0], m[7:4]};
      OP_SWAP_ACC: e.acc = {m[3:0], m[7:4]};
      OP_SKIP_NULL: e.skip = m == 8'h00;
      OP_SKIP_NULL_ACC: e = '{m, m, f, m == 8'h00};
      OP_SKIP_BIT_ZERO: e.skip = !m[b];
      OP_SKIP_BIT_ONE: e.skip = m[b];
      OP_INC_SKIP: e = '{a, m + 8'h01, f, m == 8'hFF};
      OP_DEC_SKIP: e = '{a, m - 8'h01, f, m == 8'h01};
      OP_INC_SKIP_ACC: e = '{m + 8'h01, m, f, m == 8'hFF};
      OP_DEC_SKIP_ACC: e = '{m - 8'h01, m, f, m == 8'h01};
      default: e.skip = 1'h0;
    endcase
    return e;
  endfunction : model

  initial
  begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    $display("BAD run end expected done seen timeout");
    print_verdict();
  end

  initial
  begin
    logic [31:0] r;
    logic [31:0] q;
    logic [31:0] d;
    logic [31:0] p;
    logic [7:0] ad;
    mie_op_e op;
    mie_exp_s e;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'h0;
    rd_chk("unmapped", 8'h40, 32'h0);
    for (int i = 0; i < 72; i++)
    begin
      op = (i % 24 < 19) ? ops[i % 24] : ops2[i % 24 - 19];
      r = (i < 24) ? 32'h0101FF00 : $random(seed);
      q = (i < 24) ? 32'h0 : $random(seed);
      ad = {2'h1, r[5:0]};
      e = model(op, r[15:8], r[23:16], r[27:24], q[7:0], q[10:8]);
      wr(REG_ACC, {24'h0, r[15:8]});
      wr(REG_MEM_ADDR, {24'h0, ad});
      wr(REG_MEM_DATA, {24'h0, r[23:16]});
      wr(REG_STATUS, {28'h0, r[27:24]});
      run(iw(op, ad, q[7:0], q[10:8]));
      rd_chk("acc", REG_ACC, 32'(e.acc));
      rd_chk("mem", REG_MEM_DATA, 32'(e.mem));
      rd(REG_STATUS, d);
      chk_val("flags", 32'(e.fl), 32'(d[3:0]));
      chk_bit("skip", e.skip, d[ST_SKIP]);
      run(iw(OP_NOP, 8'h00, 8'h00, 3'h0));
    end
    cyc_run(tw(OP_BRANCH, 12'h300), 2);
    rd_chk("pc", REG_PC, 32'h300);
    cyc_run(iw(OP_CLEAR, PC_LOW_ADDR, 8'h00, 3'h0), 2);
    wr(REG_PROG, 32'h03455ABC);
    wr(REG_PROG, 32'h0F451234);
    wr(REG_ACC, 32'h45);
    wr(REG_MEM_ADDR, 32'h40);
    cyc_run(iw(OP_TAB_CUR, 8'h40, 8'h00, 3'h0), 2);
    rd_chk("latch", REG_TABLE_HIGH, 32'h5A);
    rd_chk("mem", REG_MEM_DATA, 32'hBC);
    run(iw(OP_TAB_LAST, 8'h40, 8'h00, 3'h0));
    rd_chk("latch", REG_TABLE_HIGH, 32'h12);
    rd_chk("mem", REG_MEM_DATA, 32'h34);
    wr(REG_STATUS, 32'hF);
    rd(REG_PC, p);
    cyc_run(tw(OP_CALL, 12'h123), 2);
    rd_chk("pc", REG_PC, 32'h123);
    rd(REG_STATUS, d);
    chk_val("status", 32'hF, d & ~(32'h1 << ST_TIMEOUT));
    run(iw(OP_RET_VAL, 8'h00, 8'h5A, 3'h0));
    rd_chk("acc", REG_ACC, 32'h5A);
    rd_chk("pc", REG_PC, p + 32'h1);
    run(tw(OP_CALL, 12'h200));
    run(iw(OP_IRQ_RET, 8'h00, 8'h00, 3'h0));
    rd_chk("pc", REG_PC, p + 32'h2);
    rd(REG_STATUS, d);
    chk_val("status", 32'h10F, d & ~(32'h1 << ST_TIMEOUT));
    run(tw(OP_CALL, 12'h210));
    wr(REG_STATUS, 32'h200);
    run(iw(OP_IRQ_RET, 8'h00, 8'h00, 3'h0));
    rd_chk("pc", REG_PC, {20'h0, IRQ_VECTOR});
    rd(REG_STATUS, d);
    chk_val("status", 32'h0, d & ~(32'h1 << ST_TIMEOUT));
    run(iw(OP_RET, 8'h00, 8'h00, 3'h0));
    rd_chk("pc", REG_PC, p + 32'h3);
    wr(REG_ACC, 32'h10);
    wr(REG_MEM_ADDR, 32'h50);
    wr(REG_MEM_DATA, 32'h1);
    cyc_run(iw(OP_SKIP_NULL, 8'h50, 8'h00, 3'h0), 1);
    wr(REG_MEM_DATA, 32'h0);
    run(iw(OP_SKIP_NULL, 8'h50, 8'h00, 3'h0));
    cyc_run(iw(OP_ADD_IMM, 8'h00, 8'h22, 3'h0), 1);
    rd_chk("acc", REG_ACC, 32'h10);
    repeat (70) @(posedge sys_clk);
    rd(REG_STATUS, d);
    chk_bit("timeout", 1'h1, d[ST_TIMEOUT]);
    run(iw(OP_HALT, 8'h00, 8'h00, 3'h0));
    rd(REG_STATUS, d);
    chk_val("wd flags", 32'h1, 32'(d[ST_TIMEOUT:ST_PDOWN]));
    chk_bit("clk stop", 1'h1, sys_clk_stop);
    run(iw(OP_ADD_IMM, 8'h00, 8'h22, 3'h0));
    rd_chk("acc", REG_ACC, 32'h10);
    wr(REG_CTRL, 32'h1);
    @(negedge sys_clk);
    chk_bit("clk stop", 1'h0, sys_clk_stop);
    run(iw(OP_WD_PRE_A, 8'h00, 8'h00, 3'h0));
    run(iw(OP_WD_PRE_A, 8'h00, 8'h00, 3'h0));
    rd(REG_STATUS, d);
    chk_bit("powerdown", 1'h1, d[ST_PDOWN]);
    run(iw(OP_WD_PRE_B, 8'h00, 8'h00, 3'h0));
    rd(REG_STATUS, d);
    chk_bit("powerdown", 1'h0, d[ST_PDOWN]);
    repeat (70) @(posedge sys_clk);
    run(iw(OP_WD_PRE_B, 8'h00, 8'h00, 3'h0));
    run(iw(OP_WD_PRE_B, 8'h00, 8'h00, 3'h0));
    rd(REG_STATUS, d);
    chk_bit("timeout", 1'h1, d[ST_TIMEOUT]);
    run(iw(OP_WD_PRE_A, 8'h00, 8'h00, 3'h0));
    rd(REG_STATUS, d);
    chk_bit("timeout", 1'h0, d[ST_TIMEOUT]);
    run(iw(OP_HALT, 8'h00, 8'h00, 3'h0));
    wr(REG_CTRL, 32'h1);
    repeat (70) @(posedge sys_clk);
    run(iw(OP_WD_CLEAR, 8'h00, 8'h00, 3'h0));
    rd(REG_STATUS, d);
    chk_val("wd flags", 32'h0, 32'(d[ST_TIMEOUT:ST_PDOWN]));
    print_verdict();
  end
endmodule : mcu_instruction_execution_tb
`default_nettype wire
